// >>> mmuw_mem.sv
// physical memory model answering level one descriptor reads
`timescale 1ns/1ps
module mmuw_mem
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic mem_req,
   input wire logic [31:0] mem_addr,
   output logic mem_ack,
   output logic [31:0] mem_rdata
);
   logic [31:0] mem [0:15];
   int lat;
   int cnt;
   // lat is set by the bench before each table row walk; later walks keep the last value
   // data is scrambled outside the ack cycle so a late sample shows up
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mem_ack <= 1'b0;
         mem_rdata <= 32'h0;
         cnt <= 0;
      end
      else if (mem_ack)
      begin
         mem_ack <= 1'b0;
         mem_rdata <= ~mem_rdata;
         cnt <= 0;
      end
      else if (mem_req && cnt + 1 >= lat)
      begin
         mem_ack <= 1'b1;
         mem_rdata <= mem[mem_addr[5:2]];
      end
      else
      begin
         cnt <= mem_req ? cnt + 1 : 0;
         mem_rdata <= mem_rdata ^ 32'h5a5a_5a5a;
      end
   end
endmodule

// >>> mmuw_pkg.sv
// shared constants, types and helpers for the level one translation walk
package mmuw_pkg;
   // register numbers carried by the coprocessor transfers
   localparam logic [3:0] REG_CONTROL = 4'h1;
   localparam logic [3:0] REG_TABLE_BASE = 4'h2;
   localparam logic [3:0] REG_DOMAIN = 4'h3;
   localparam logic [3:0] REG_FAULT = 4'h5;
   localparam logic [3:0] REG_FAULT_ADDR = 4'h6;
   // control word bit positions
   localparam int CTL_MMU_BIT = 0;
   localparam int CTL_CACHE_BIT = 2;
   localparam int CTL_WBUF_BIT = 3;
   localparam int CTL_SYS_BIT = 8;
   localparam int CTL_ROM_BIT = 9;
   // values after reset
   localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
   localparam logic [31:0] TABLE_BASE_RESET = 32'h0000_0000;
   localparam logic [31:0] DOMAIN_RESET = 32'h0000_0000;
   localparam logic [7:0] FAULT_RESET = 8'h00;
   localparam logic [31:0] FAULT_ADDR_RESET = 32'h0000_0000;
   // table base alignment and descriptor field positions
   localparam int TB_LOW_BITS = 14;
   localparam int SEC_LSB = 20;
   localparam int PT_BASE_LSB = 10;
   localparam int PERM_LSB = 10;
   localparam int DOM_LSB = 5;
   localparam int BUF_BIT = 2;
   localparam int CACHE_BIT = 3;
   // descriptor type codes in bits 1:0
   localparam logic [1:0] DESC_INVALID = 2'h0;
   localparam logic [1:0] DESC_PAGE = 2'h1;
   localparam logic [1:0] DESC_SECTION = 2'h2;
   localparam logic [1:0] DESC_RESERVED = 2'h3;
   // fault status codes
   localparam logic [3:0] FS_TRANS_SECTION = 4'h5;
   localparam logic [3:0] FS_DOMAIN_SECTION = 4'h9;
   localparam logic [3:0] FS_PERM_SECTION = 4'hd;
   // domain field codes
   localparam logic [1:0] DOM_CLIENT = 2'h1;
   localparam logic [1:0] DOM_MANAGER = 2'h3;
   // translation buffer size
   localparam int TLB_ENTRIES = 64;
   localparam int TLB_IDX_W = 6;

   typedef enum logic [1:0] {WALK_FAULT, WALK_SECTION, WALK_PAGE} mmuw_res_t;

   // permission code check, with the system and rom control bits
   function automatic logic mmuw_perm_ok(input logic [1:0] code,
      input logic s, input logic r, input logic user, input logic wr);
      logic ok;
      ok = 1'b0;
      case (code)
         2'h3: ok = 1'b1;
         2'h2: ok = !user || !wr;
         2'h1: ok = !user;
         default: ok = !wr && ((s && !r && !user) || (!s && r));
      endcase
      return ok;
   endfunction
endpackage

// >>> mmuw_tlb.sv
// translation buffer of section entries with round-robin refill
`timescale 1ns/1ps
module mmuw_tlb
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [11:0] look_tag,
   output logic hit,
   output logic [31:0] hit_desc,
   input wire logic fill,
   input wire logic [11:0] fill_tag,
   input wire logic [31:0] fill_desc,
   input wire logic flush_all,
   input wire logic purge,
   input wire logic [11:0] purge_tag
);
   import mmuw_pkg::*;

   logic [TLB_ENTRIES-1:0] valid_q;
   logic [11:0] tag_q [TLB_ENTRIES];
   logic [31:0] desc_q [TLB_ENTRIES];
   logic [TLB_IDX_W-1:0] rr_q;

   function automatic logic [TLB_IDX_W:0] find(input logic [11:0] t);
      logic [TLB_IDX_W:0] res;
      res = '0;
      for (int i = 0; i < TLB_ENTRIES; i++)
         if (valid_q[i] && tag_q[i] == t)
            res = {1'b1, TLB_IDX_W'(i)};
      return res;
   endfunction

   logic [TLB_IDX_W:0] look_r;
   logic [TLB_IDX_W:0] purge_r;
   assign look_r = find(look_tag);
   assign purge_r = find(purge_tag);
   assign hit = look_r[TLB_IDX_W];
   assign hit_desc = desc_q[look_r[TLB_IDX_W-1:0]];

   // a flush in the same cycle as a fill leaves the buffer empty
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         valid_q <= '0;
      else if (flush_all)
         valid_q <= '0;
      else
      begin
         if (purge && purge_r[TLB_IDX_W])
            valid_q[purge_r[TLB_IDX_W-1:0]] <= 1'b0;
         if (fill)
            valid_q[rr_q] <= 1'b1;
      end
   end

   always_ff @(posedge clk)
   begin
      if (fill)
      begin
         tag_q[rr_q] <= fill_tag;
         desc_q[rr_q] <= fill_desc;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         rr_q <= '0;
      else if (fill)
         rr_q <= rr_q + 1'b1; // see R20
   end
endmodule

// >>> mmuw_top.sv
// memory management unit registers and level one translation walk
//
// Contract
// R01 - every control and status register is a 32-bit word
// R02 - software uses coprocessor transfers only, never reserved numbers
// R03 - table base keeps its low 14 bits zero, 16-Kbyte aligned
// R04 - domain rights hold sixteen 2-bit fields, one per domain
// R05 - fault cause holds domain in 7:4, type in 3:1, origin bit 0
// R06 - any write to the fault cause number flushes the whole buffer
// R07 - fault address captures the virtual address of the faulting access
// R08 - write to fault address number purges the matching buffer entry
// R09 - fault registers change only on data faults, never on prefetch
// R10 - a walk starts only when the buffer misses
// R11 - level one address is base bits 31:14 with address bits 31:20
// R12 - sections finish after level one; pages need a level two fetch
// R13 - descriptor code 00 invalid, 01 page table, 10 section, 11 reserved
// R14 - page table base is descriptor bits 31:10, then level two begins
// R15 - descriptor bits 8:5 select the governing domain field
// R16 - software writes zeros and a one in the fixed descriptor bits
// R17 - section bits 3:2 give cacheable and bufferable, gated by enables
// R18 - permission code in bits 11:10 applies only to client domains
// R19 - section physical address takes bits 31:20 from the descriptor
// R20 - refill victim steps round-robin through the buffer
// R21 - while the unit is off addresses pass through untranslated
// R22 - code 11 allows all; code 01 allows supervisor only
// R23 - reserved descriptor code raises a section translation fault
// R24 - descriptor fetches are single uncached, unbuffered word reads
`timescale 1ns/1ps
module mmuw_top
(
   input wire logic MCLK,
   input wire logic RSTN,
   input wire logic CP_WR,
   input wire logic CP_RD,
   input wire logic [3:0] CP_REG,
   input wire logic [31:0] CP_WDATA,
   output logic [31:0] CP_RDATA,
   output logic CP_ACK,
   output logic CP_UNDEF,
   input wire logic REQ,
   input wire logic [31:0] VA,
   input wire logic REQ_WRITE,
   input wire logic REQ_USER,
   input wire logic REQ_DATA,
   output logic DONE,
   output logic ABORT,
   output logic [31:0] PA,
   output logic PA_CACHEABLE,
   output logic PA_BUFFERABLE,
   output logic L2_START,
   output logic [21:0] L2_BASE,
   output logic [3:0] L2_DOMAIN,
   output logic [31:0] L2_VA,
   output logic MEM_REQ,
   output logic [31:0] MEM_ADDR,
   output logic MEM_BYPASS,
   input wire logic MEM_ACK,
   input wire logic [31:0] MEM_RDATA
);
   import mmuw_pkg::*;

   typedef enum logic [1:0] {ST_IDLE, ST_LOOK, ST_WALK} mmuw_state_t;

   // the access is latched at acceptance and held for the whole walk
   mmuw_state_t state_q;
   logic [31:0] control_q;
   logic [31:0] table_base_q;
   logic [31:0] domain_q;
   logic [7:0] fault_q;
   logic [31:0] fault_addr_q;
   logic [31:0] va_q;
   logic write_q;
   logic user_q;
   logic data_q;
   logic tlb_hit;
   logic [31:0] tlb_desc;
   logic walk_start;
   logic walk_done;
   mmuw_res_t walk_res;
   logic [31:0] walk_desc;
   logic tlb_fill;
   logic tlb_flush;
   logic tlb_purge;
   logic mmu_on;
   logic [1:0] dom_code;
   logic perm_ok;
   logic fault_now;
   logic [3:0] fault_code;
   logic [3:0] fault_dom;

   // with the enable bit clear a request never leaves idle
   assign mmu_on = control_q[CTL_MMU_BIT];

   // register writes; reads of write-only words trap as undefined
   function automatic logic reg_known(input logic [3:0] n, input logic wr);
      logic k;
      k = 1'b0;
      case (n)
         REG_CONTROL, REG_TABLE_BASE, REG_DOMAIN: k = 1'b1;
         REG_FAULT, REG_FAULT_ADDR: k = 1'b1;
         default: k = 1'b0;
      endcase
      return k && (wr || n >= REG_FAULT);
   endfunction

   always_ff @(posedge MCLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         control_q <= CONTROL_RESET;
         table_base_q <= TABLE_BASE_RESET;
         domain_q <= DOMAIN_RESET;
      end
      else if (CP_WR)
      begin
         case (CP_REG)
            REG_CONTROL: control_q <= CP_WDATA; // see R01
            REG_TABLE_BASE:
               table_base_q <= {CP_WDATA[31:TB_LOW_BITS],
                  TB_LOW_BITS'(0)}; // see R03
            REG_DOMAIN: domain_q <= CP_WDATA; // see R04
            default: ;
         endcase
      end
   end

   // flush and purge act on the buffer in the cycle of the write
   assign tlb_flush = CP_WR && CP_REG == REG_FAULT; // see R06
   assign tlb_purge = CP_WR && CP_REG == REG_FAULT_ADDR; // see R08

   always_ff @(posedge MCLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         CP_RDATA <= '0;
         CP_ACK <= 1'b0;
         CP_UNDEF <= 1'b0;
      end
      else
      begin
         CP_ACK <= (CP_WR || CP_RD) && reg_known(CP_REG, CP_WR);
         // reserved numbers trap rather than act
         CP_UNDEF <= (CP_WR || CP_RD) && !reg_known(CP_REG, CP_WR); // see R02
         if (CP_RD && CP_REG == REG_FAULT)
            CP_RDATA <= {24'h0, fault_q}; // see R05
         else if (CP_RD && CP_REG == REG_FAULT_ADDR)
            CP_RDATA <= fault_addr_q;
         else if (CP_RD)
            CP_RDATA <= '0;
      end
   end

   // lookups use the latched address so the answer cannot follow VA
   // purge compares only the section bits of the written word
   mmuw_tlb mmuw_tlb_inst
   (
      .clk(MCLK),
      .rst_n(RSTN),
      .look_tag(va_q[31:SEC_LSB]),
      .hit(tlb_hit),
      .hit_desc(tlb_desc),
      .fill(tlb_fill),
      .fill_tag(va_q[31:SEC_LSB]),
      .fill_desc(walk_desc),
      .flush_all(tlb_flush),
      .purge(tlb_purge),
      .purge_tag(CP_WDATA[31:SEC_LSB])
   );

   // one descriptor read at a time; start is ignored while a read waits
   mmuw_walk mmuw_walk_inst
   (
      .clk(MCLK),
      .rst_n(RSTN),
      .start(walk_start),
      .table_base(table_base_q),
      .va(va_q),
      .mem_req_q(MEM_REQ),
      .mem_addr_q(MEM_ADDR),
      .mem_ack(MEM_ACK),
      .mem_rdata(MEM_RDATA),
      .done_q(walk_done),
      .res_q(walk_res),
      .desc_q(walk_desc)
   );

   // descriptor fetches never go through the cache or write buffer
   always_ff @(posedge MCLK or negedge RSTN)
   begin
      if (!RSTN)
         MEM_BYPASS <= 1'b0;
      else
         MEM_BYPASS <= walk_start || (MEM_REQ && !MEM_ACK); // see R24
   end

   // buffer hit checks: domain field, then permission code
   assign dom_code = domain_q[2*tlb_desc[DOM_LSB +: 4] +: 2]; // see R15
   assign perm_ok = mmuw_perm_ok(tlb_desc[PERM_LSB +: 2],
      control_q[CTL_SYS_BIT], control_q[CTL_ROM_BIT],
      user_q, write_q); // see R22

   // a miss launches the walk; a hit never does
   assign walk_start = state_q == ST_LOOK && !tlb_hit; // see R10
   // only a section result is cached, then looked up again
   assign tlb_fill = state_q == ST_WALK && walk_done
      && walk_res == WALK_SECTION; // see R12

   // fault priority: translation first, then domain, then permission
   always_comb
   begin
      fault_now = 1'b0;
      fault_code = FS_TRANS_SECTION;
      fault_dom = tlb_desc[DOM_LSB +: 4];
      if (state_q == ST_WALK && walk_done && walk_res == WALK_FAULT)
      begin
         // invalid and reserved codes both end here
         fault_now = 1'b1;
         fault_dom = walk_desc[DOM_LSB +: 4]; // see R13
      end
      else if (state_q == ST_LOOK && tlb_hit)
      begin
         if (dom_code != DOM_CLIENT && dom_code != DOM_MANAGER)
         begin
            fault_now = 1'b1;
            fault_code = FS_DOMAIN_SECTION;
         end
         else if (dom_code == DOM_CLIENT && !perm_ok)
         begin
            fault_now = 1'b1; // see R18
            fault_code = FS_PERM_SECTION;
         end
      end
   end

   always_ff @(posedge MCLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         state_q <= ST_IDLE;
         va_q <= '0;
         write_q <= 1'b0;
         user_q <= 1'b0;
         data_q <= 1'b0;
      end
      else
      begin
         // a refill goes back to lookup so hit checks live in one place
         // trade-off: one extra cycle per section miss, but no second check path
         case (state_q)
            ST_IDLE:
               if (REQ && mmu_on)
               begin
                  state_q <= ST_LOOK;
                  va_q <= VA;
                  write_q <= REQ_WRITE;
                  user_q <= REQ_USER;
                  data_q <= REQ_DATA;
               end
            ST_LOOK:
               if (tlb_hit)
                  state_q <= ST_IDLE;
               else
                  state_q <= ST_WALK;
            ST_WALK:
               if (walk_done && walk_res == WALK_SECTION)
                  state_q <= ST_LOOK;
               else if (walk_done)
                  state_q <= ST_IDLE;
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // answers to the core: pass-through, translated or aborted
   always_ff @(posedge MCLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         DONE <= 1'b0;
         ABORT <= 1'b0;
         PA <= '0;
         PA_CACHEABLE <= 1'b0;
         PA_BUFFERABLE <= 1'b0;
      end
      else
      begin
         DONE <= 1'b0;
         ABORT <= fault_now;
         if (state_q == ST_IDLE && REQ && !mmu_on)
         begin
            DONE <= 1'b1;
            PA <= VA; // see R21
            PA_CACHEABLE <= 1'b0;
            PA_BUFFERABLE <= 1'b0;
         end
         else if (state_q == ST_LOOK && tlb_hit && !fault_now)
         begin
            DONE <= 1'b1;
            // section frame on top, offset from the virtual address
            PA <= {tlb_desc[31:SEC_LSB], va_q[SEC_LSB-1:0]}; // see R19
            PA_CACHEABLE <= tlb_desc[CACHE_BIT]
               && control_q[CTL_CACHE_BIT]; // see R17
            PA_BUFFERABLE <= tlb_desc[BUF_BIT]
               && control_q[CTL_WBUF_BIT]; // see R17
         end
      end
   end

   // page table results go to the level two stage
   // no answer to the core here; the level two stage owns the reply
   always_ff @(posedge MCLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         L2_START <= 1'b0;
         L2_BASE <= '0;
         L2_DOMAIN <= '0;
         L2_VA <= '0;
      end
      else
      begin
         L2_START <= state_q == ST_WALK && walk_done
            && walk_res == WALK_PAGE; // see R12
         if (state_q == ST_WALK && walk_done && walk_res == WALK_PAGE)
         begin
            L2_BASE <= walk_desc[31:PT_BASE_LSB]; // see R14
            L2_DOMAIN <= walk_desc[DOM_LSB +: 4]; // see R15
            L2_VA <= va_q;
         end
      end
   end

   // prefetch faults abort but leave the recorded fault alone
   // the origin bit rides in the low bit of every fault code
   always_ff @(posedge MCLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         fault_q <= FAULT_RESET;
         fault_addr_q <= FAULT_ADDR_RESET;
      end
      else if (fault_now && data_q) // see R09
      begin
         fault_q <= {fault_dom, fault_code}; // see R05
         fault_addr_q <= va_q; // see R07
      end
   end
endmodule

// >>> mmuw_top_monitor.sv
// concurrent checks on the translation walk top ports
`timescale 1ns/1ps
module mmuw_top_monitor
   import mmuw_pkg::*;
(
   input wire logic MCLK,
   input wire logic RSTN,
   input wire logic CP_WR,
   input wire logic [3:0] CP_REG,
   input wire logic [31:0] CP_WDATA,
   input wire logic REQ,
   input wire logic [31:0] VA,
   input wire logic DONE,
   input wire logic ABORT,
   input wire logic [31:0] PA,
   input wire logic PA_CACHEABLE,
   input wire logic PA_BUFFERABLE,
   input wire logic L2_START,
   input wire logic [21:0] L2_BASE,
   input wire logic [3:0] L2_DOMAIN,
   input wire logic MEM_REQ,
   input wire logic [31:0] MEM_ADDR,
   input wire logic MEM_BYPASS,
   input wire logic MEM_ACK,
   input wire logic [31:0] MEM_RDATA
);
   logic en_q;
   logic cache_q;
   logic [31:0] base_q;
   logic [31:0] va_q;
   logic busy_q;
   logic start;
   assign start = REQ && (!busy_q || DONE || ABORT || L2_START);
   default clocking mon_cb @(posedge MCLK);
   endclocking
   default disable iff (!RSTN);
   always_ff @(posedge MCLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         en_q <= 1'b0;
         cache_q <= 1'b0;
         base_q <= 32'h0;
      end
      else if (CP_WR && CP_REG == REG_CONTROL)
      begin
         en_q <= CP_WDATA[CTL_MMU_BIT];
         cache_q <= CP_WDATA[CTL_CACHE_BIT];
      end
      else if (CP_WR && CP_REG == REG_TABLE_BASE)
         base_q <= CP_WDATA;
   end
   always_ff @(posedge MCLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         busy_q <= 1'b0;
         va_q <= 32'h0;
      end
      else if (start)
      begin
         busy_q <= 1'b1;
         va_q <= VA;
      end
      else if (DONE || ABORT || L2_START)
         busy_q <= 1'b0;
   end
   a_off_passthru: assert property (start && !en_q |=> DONE
      && PA == $past(VA) && !PA_CACHEABLE && !PA_BUFFERABLE)
      else $error("pass-through result wrong");
   a_walk_addr: assert property ($rose(MEM_REQ) |->
      MEM_ADDR == {base_q[31:14], va_q[31:20], 2'b00})
      else $error("descriptor address wrong");
   a_fetch_bypass: assert property (MEM_REQ |-> MEM_BYPASS)
      else $error("descriptor fetch not bypassed");
   a_walk_cause: assert property ($rose(MEM_REQ) |->
      $past(start, 2) && en_q)
      else $error("walk without a translated request");
   a_page_handoff: assert property (MEM_REQ && MEM_ACK
      && MEM_RDATA[1:0] == DESC_PAGE |-> ##2 L2_START
      && L2_BASE == $past(MEM_RDATA[31:10], 2)
      && L2_DOMAIN == $past(MEM_RDATA[8:5], 2))
      else $error("page table handoff wrong");
   a_bad_desc: assert property (MEM_REQ && MEM_ACK
      && MEM_RDATA[1] == MEM_RDATA[0] |-> ##2 ABORT)
      else $error("invalid descriptor not aborted");
   a_section_pa: assert property (MEM_REQ && MEM_ACK
      && MEM_RDATA[1:0] == DESC_SECTION |-> ##3 ABORT
      || DONE && PA == {$past(MEM_RDATA[31:20], 3), va_q[19:0]})
      else $error("section address wrong");
   a_cache_gate: assert property (DONE && !cache_q |->
      !PA_CACHEABLE)
      else $error("cacheable while cache off");
   cover property (DONE && en_q);
   cover property (ABORT);
   cover property (L2_START);
endmodule
bind mmuw_top mmuw_top_monitor mmuw_top_monitor_inst (.MCLK(MCLK),
   .RSTN(RSTN), .CP_WR(CP_WR), .CP_REG(CP_REG), .CP_WDATA(CP_WDATA),
   .REQ(REQ), .VA(VA), .DONE(DONE), .ABORT(ABORT), .PA(PA),
   .PA_CACHEABLE(PA_CACHEABLE), .PA_BUFFERABLE(PA_BUFFERABLE),
   .L2_START(L2_START), .L2_BASE(L2_BASE), .L2_DOMAIN(L2_DOMAIN),
   .MEM_REQ(MEM_REQ), .MEM_ADDR(MEM_ADDR), .MEM_BYPASS(MEM_BYPASS),
   .MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA));

// >>> mmuw_top_tb.sv
// self-checking bench for the translation walk top
`timescale 1ns/1ps
module mmuw_top_tb;
   import mmuw_pkg::*;
   typedef struct packed {
      logic [31:0] va;
      logic [31:0] desc;
      logic [2:0] at;
      logic [2:0] kind;
      logic walk;
      logic [31:0] pa;
      logic [1:0] cb;
      logic [7:0] fsr;
      logic [31:0] far;
   } mmuw_row_t;
   logic MCLK, RSTN, CP_WR, CP_RD, REQ, REQ_WRITE, REQ_USER, REQ_DATA;
   logic [3:0] CP_REG, L2_DOMAIN;
   logic [31:0] CP_WDATA, CP_RDATA, VA, PA, L2_VA, MEM_ADDR, MEM_RDATA;
   logic CP_ACK, CP_UNDEF, DONE, ABORT, PA_CACHEABLE, PA_BUFFERABLE;
   logic L2_START, MEM_REQ, MEM_BYPASS, MEM_ACK, un, seen;
   logic [21:0] L2_BASE;
   logic [31:0] rd;
   logic [2:0] kind;
   int n_mismatch, samples_checked;
   mmuw_row_t rows [0:7];
   mmuw_top mmuw_top_inst (.MCLK(MCLK), .RSTN(RSTN), .CP_WR(CP_WR),
      .CP_RD(CP_RD), .CP_REG(CP_REG), .CP_WDATA(CP_WDATA),
      .CP_RDATA(CP_RDATA), .CP_ACK(CP_ACK), .CP_UNDEF(CP_UNDEF),
      .REQ(REQ), .VA(VA), .REQ_WRITE(REQ_WRITE), .REQ_USER(REQ_USER),
      .REQ_DATA(REQ_DATA), .DONE(DONE), .ABORT(ABORT), .PA(PA),
      .PA_CACHEABLE(PA_CACHEABLE), .PA_BUFFERABLE(PA_BUFFERABLE),
      .L2_START(L2_START), .L2_BASE(L2_BASE), .L2_DOMAIN(L2_DOMAIN),
      .L2_VA(L2_VA), .MEM_REQ(MEM_REQ), .MEM_ADDR(MEM_ADDR),
      .MEM_BYPASS(MEM_BYPASS), .MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA));
   mmuw_mem mmuw_mem_inst (.clk(MCLK), .rst_n(RSTN), .mem_req(MEM_REQ),
      .mem_addr(MEM_ADDR), .mem_ack(MEM_ACK), .mem_rdata(MEM_RDATA));
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic cp(input logic w, input logic [3:0] r,
      input logic [31:0] d);
      @(negedge MCLK);
      CP_WR = w;
      CP_RD = !w;
      CP_REG = r;
      CP_WDATA = d;
      @(negedge MCLK);
      CP_WR = 1'b0;
      CP_RD = 1'b0;
      chk(CP_ACK ^ CP_UNDEF, 1'b1);
      rd = CP_RDATA;
      un = CP_UNDEF;
   endtask
   // bound the wait so a design that never answers still ends the run
   task automatic acc(input logic [31:0] va, input logic [2:0] at);
      int n;
      @(negedge MCLK);
      {REQ_USER, REQ_WRITE, REQ_DATA} = at;
      VA = va;
      REQ = 1'b1;
      @(negedge MCLK);
      REQ = 1'b0;
      seen = 1'b0;
      for (n = 0; n < 60 && {L2_START, ABORT, DONE} === 3'h0; n++)
      begin
         seen |= MEM_REQ === 1'b1;
         @(negedge MCLK);
      end
      kind = {L2_START, ABORT, DONE};
      if (n == 60)
      begin
         n_mismatch++;
         give_verdict();
      end
   endtask
   initial
   begin
      MCLK = 1'b0;
      forever #12.5 MCLK = ~MCLK;
   end
   initial
   begin
      // va, descriptor, {user,write,data}, answer, walk, pa, c/b, fsr, far
      rows = '{
         '{32'h0010_0abc, 32'h8000_0c1e, 3'h7, 3'h1, 1'b1, 32'h8000_0abc,
            2'h3, 8'h00, 32'h0},
         '{32'h0020_0004, 32'h9000_0412, 3'h7, 3'h2, 1'b1, 32'h0,
            2'h0, 8'h0d, 32'h0020_0004},
         '{32'h0030_0000, 32'h0000_0030, 3'h1, 3'h2, 1'b1, 32'h0,
            2'h0, 8'h15, 32'h0030_0000},
         '{32'h0040_0000, 32'h0000_0053, 3'h0, 3'h2, 1'b1, 32'h0,
            2'h0, 8'h15, 32'h0030_0000},
         '{32'h0050_0000, 32'h7654_0c31, 3'h1, 3'h4, 1'b1, 32'h0,
            2'h0, 8'h15, 32'h0030_0000},
         '{32'h0060_0123, 32'ha000_0032, 3'h7, 3'h1, 1'b1, 32'ha000_0123,
            2'h0, 8'h15, 32'h0030_0000},
         '{32'h0010_0004, 32'h8000_0c1e, 3'h1, 3'h1, 1'b0, 32'h8000_0004,
            2'h3, 8'h15, 32'h0030_0000},
         '{32'h0070_0000, 32'h7000_0052, 3'h1, 3'h2, 1'b1, 32'h0,
            2'h0, 8'h29, 32'h0070_0000}};
      {RSTN, CP_WR, CP_RD, REQ, REQ_WRITE, REQ_USER, REQ_DATA} = 7'h0;
      CP_REG = 4'h0;
      CP_WDATA = 32'h0;
      VA = 32'h0;
      n_mismatch = 0;
      samples_checked = 0;
      repeat (6) @(negedge MCLK);
      RSTN = 1'b1;
      cp(1'b1, REG_TABLE_BASE, 32'h1234_5fff);
      cp(1'b1, REG_DOMAIN, 32'h0000_000d);
      cp(1'b1, REG_CONTROL, 32'h0000_000d);
      foreach (rows[i])
      begin
         mmuw_mem_inst.mem[rows[i].va[23:20]] = rows[i].desc;
         mmuw_mem_inst.lat = i % 3 + 1;
         acc(rows[i].va, rows[i].at);
         chk(kind, rows[i].kind);
         chk(seen, rows[i].walk);
         if (rows[i].kind == 3'h1)
         begin
            chk(PA, rows[i].pa);
            chk({PA_CACHEABLE, PA_BUFFERABLE}, rows[i].cb);
         end
         if (rows[i].kind == 3'h4)
         begin
            chk(L2_BASE, rows[i].desc[31:10]);
            chk(L2_DOMAIN, rows[i].desc[8:5]);
            chk(L2_VA, rows[i].va);
         end
         cp(1'b0, REG_FAULT, 32'h0);
         chk(rd, {24'h0, rows[i].fsr});
         cp(1'b0, REG_FAULT_ADDR, 32'h0);
         chk(rd, rows[i].far);
      end
      for (int r = 0; r < 16; r++)
      begin
         cp(1'b0, r[3:0], 32'h0);
         chk(un, r != 5 && r != 6);
         if (!(r inside {1, 2, 3, 5, 6}))
         begin
            cp(1'b1, r[3:0], 32'hffff_ffff);
            chk(un, 1'b1);
         end
      end
      mmuw_mem_inst.mem[1] = 32'h8100_0c1e;
      cp(1'b1, REG_FAULT_ADDR, 32'h0aa0_0000);
      acc(32'h0060_0123, 3'h1);
      chk(seen, 1'b0);
      cp(1'b1, REG_FAULT_ADDR, 32'h0010_0000);
      acc(32'h0010_0abc, 3'h1);
      chk({seen, PA}, {1'b1, 32'h8100_0abc});
      cp(1'b1, REG_CONTROL, 32'h0000_0001);
      cp(1'b1, REG_FAULT, 32'h1234_5678);
      acc(32'h0060_0123, 3'h7);
      chk({seen, PA_CACHEABLE, PA}, {2'h2, 32'ha000_0123});
      acc(32'h0010_0abc, 3'h1);
      chk({seen, PA_CACHEABLE, PA_BUFFERABLE}, 3'h4);
      cp(1'b1, REG_CONTROL, 32'h0);
      acc(32'hfedc_ba98, 3'h7);
      chk({kind, seen, PA}, {4'h2, 32'hfedc_ba98});
      @(negedge MCLK);
      RSTN = 1'b0;
      @(negedge MCLK);
      RSTN = 1'b1;
      cp(1'b0, REG_FAULT, 32'h0);
      chk(rd, {24'h0, FAULT_RESET});
      cp(1'b0, REG_FAULT_ADDR, 32'h0);
      chk(rd, FAULT_ADDR_RESET);
      give_verdict();
   end
endmodule

// >>> mmuw_walk.sv
// level one descriptor fetch and decode
`timescale 1ns/1ps
module mmuw_walk
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic start,
   input wire logic [31:0] table_base,
   input wire logic [31:0] va,
   output logic mem_req_q,
   output logic [31:0] mem_addr_q,
   input wire logic mem_ack,
   input wire logic [31:0] mem_rdata,
   output logic done_q,
   output mmuw_pkg::mmuw_res_t res_q,
   output logic [31:0] desc_q
);
   import mmuw_pkg::*;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mem_req_q <= 1'b0;
         mem_addr_q <= '0;
      end
      else if (start && !mem_req_q)
      begin
         mem_req_q <= 1'b1;
         // word address of the level one entry, low two bits zero
         mem_addr_q <= {table_base[31:TB_LOW_BITS], va[31:SEC_LSB],
            2'h0}; // see R11
      end
      else if (mem_ack)
         mem_req_q <= 1'b0;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         done_q <= 1'b0;
         res_q <= WALK_FAULT;
         desc_q <= '0;
      end
      else
      begin
         done_q <= mem_req_q && mem_ack;
         if (mem_req_q && mem_ack)
         begin
            desc_q <= mem_rdata;
            case (mem_rdata[1:0]) // see R13
               DESC_PAGE: res_q <= WALK_PAGE;
               DESC_SECTION: res_q <= WALK_SECTION;
               DESC_RESERVED: res_q <= WALK_FAULT; // see R23
               default: res_q <= WALK_FAULT;
            endcase
         end
      end
   end
endmodule
